// ### rtl/buck_pkg.sv
package buck_pkg;
	// Register indices
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_ENABLE = 4'h1;
	localparam logic [3:0] ADDR_STARTUP = 4'h2;
	localparam logic [3:0] ADDR_VCHANGE = 4'h3;
	localparam logic [3:0] ADDR_RAMP = 4'h4;
	localparam logic [3:0] ADDR_R1_T1 = 4'h5;
	localparam logic [3:0] ADDR_T1 = 4'h6;
	localparam logic [3:0] ADDR_T2 = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_RAMP = 8'h3f;
	localparam logic [7:0] RST_TARGET = 8'h19;
	// Field positions for regulator 3; EDGE_LSB is in regulator 1's target register
	localparam int MODE_LSB = 4;
	localparam int EN_BIT = 2;
	localparam int START_BIT = 2;
	localparam int REFSEL_BIT = 5;
	localparam int SLEW_BIT = 4;
	localparam int RAMP_LSB = 4;
	localparam int PGMASK_BIT = 5;
	localparam int FREQ_BIT = 5;
	localparam int PHASE_BIT = 6;
	localparam int ALIVE_BIT = 7;
	localparam int EDGE_LSB = 6;
	// Go bits of all regulators never store
	localparam logic [7:0] VCHANGE_GO_MASK = 8'h15;
	// Operating modes
	localparam logic [1:0] MODE_PSKIP = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_FCCM = 2'h2;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_KHZ = 100000;
	localparam int US_NS = 1000;
	localparam logic [6:0] TICK_CYC = 7'(US_NS / CLK_PERIOD_NS);
	localparam int FULL_FREQ_KHZ = 2250;
	localparam int HALF_FREQ_KHZ = 1125;
	localparam int FULL_HI_PCT = 20;
	localparam int HALF_HI_PCT = 50;
	localparam logic [7:0] FULL_PER = 8'(CLK_KHZ / FULL_FREQ_KHZ);
	localparam logic [7:0] HALF_PER = 8'(CLK_KHZ / HALF_FREQ_KHZ);
	localparam logic [7:0] FULL_HI = 8'(CLK_KHZ / FULL_FREQ_KHZ * FULL_HI_PCT / 100);
	localparam logic [7:0] HALF_HI = 8'(CLK_KHZ / HALF_FREQ_KHZ * HALF_HI_PCT / 100);
	// Slew steps in uV per microsecond
	localparam logic [19:0] STEP_0P88 = 20'd880;
	localparam logic [19:0] STEP_1P75 = 20'd1750;
	localparam logic [19:0] STEP_3P5 = 20'd3500;
	localparam logic [19:0] STEP_7 = 20'd7000;
	localparam logic [19:0] STEP_SOFT = 20'd800;

	typedef struct packed {
		logic en;
		logic [3:0] addr;
		logic [7:0] data;
	} wr_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_WAIT = 5'b00010,
		ST_SOFT = 5'b00100,
		ST_RUN = 5'b01000,
		ST_SLEW = 5'b10000
	} state_t;
endpackage

// ### rtl/buck_regulator_control.sv
module buck_regulator_control #(
	parameter int LSB_UV = 12500,
	parameter bit IMMEDIATE_ON_ZERO = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire buck_pkg::wr_t i_wr,
	input wire logic [3:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	input wire logic i_out_low,
	input wire logic i_fault,
	input wire logic i_shutdown,
	input wire logic i_pg_raw,
	output logic [1:0] o_mode,
	output logic o_run,
	output logic o_power_good,
	output logic [19:0] o_ref_uv,
	output logic o_sw_clk,
	output logic o_cycle_start,
	output logic o_half_rate,
	output logic [1:0] o_edge_rate
);
	import buck_pkg::*;

	logic [7:0] mode_select;
	logic [7:0] output_enable;
	logic [7:0] startup_option;
	logic [7:0] voltage_change_control;
	logic [7:0] ramp_rate_control;
	logic [7:0] reg1_target_one;
	logic [7:0] reg3_target_one;
	logic [7:0] reg3_target_two;
	logic slew_req;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [1:0] pg_sync;
	logic out_low_s;
	logic fault_s;
	logic shut_s;
	state_t state;
	state_t next_state;
	logic [19:0] ref_uv;
	logic [19:0] next_ref;
	logic [19:0] target;
	logic [19:0] step;
	logic [6:0] tick_cnt;
	logic tick;
	logic [7:0] sw_cnt;
	logic [7:0] per;
	logic [7:0] hi;
	logic [7:0] off;
	logic [7:0] shifted;
	logic stop;
	logic wait_sel;
	logic wr_hit;

	assign wr_hit = i_wr.en;

	// Register writes
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_select <= RST_ZERO;
			output_enable <= RST_ZERO;
			startup_option <= RST_ZERO;
			voltage_change_control <= RST_ZERO;
			ramp_rate_control <= RST_RAMP;
			reg1_target_one <= RST_TARGET;
			reg3_target_one <= RST_TARGET;
			reg3_target_two <= RST_TARGET;
		end else if (wr_hit) begin
			case (i_wr.addr)
				ADDR_MODE: mode_select <= i_wr.data;
				ADDR_ENABLE: output_enable <= i_wr.data;
				ADDR_STARTUP: startup_option <= i_wr.data;
				ADDR_VCHANGE: voltage_change_control <= i_wr.data & ~VCHANGE_GO_MASK;
				ADDR_RAMP: ramp_rate_control <= i_wr.data;
				ADDR_R1_T1: reg1_target_one <= i_wr.data;
				ADDR_T1: reg3_target_one <= i_wr.data;
				ADDR_T2: reg3_target_two <= i_wr.data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			slew_req <= 1'b0;
		end else if (wr_hit && i_wr.addr == ADDR_VCHANGE && i_wr.data[SLEW_BIT]) begin
			slew_req <= 1'b1;
		end else if (state == ST_RUN || state == ST_OFF) begin
			slew_req <= 1'b0;
		end
	end

	// Registered read port
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rd_data <= RST_ZERO;
		end else begin
			case (i_rd_addr)
				ADDR_MODE: o_rd_data <= mode_select;
				ADDR_ENABLE: o_rd_data <= output_enable;
				ADDR_STARTUP: o_rd_data <= startup_option;
				ADDR_VCHANGE: o_rd_data <= voltage_change_control;
				ADDR_RAMP: o_rd_data <= ramp_rate_control;
				ADDR_R1_T1: o_rd_data <= reg1_target_one;
				ADDR_T1: o_rd_data <= reg3_target_one;
				ADDR_T2: o_rd_data <= reg3_target_two;
				ADDR_STATUS: o_rd_data <= {2'h0, o_power_good, slew_req, state[4:1]};
				default: o_rd_data <= RST_ZERO;
			endcase
		end
	end

	// Pin synchronisers; first stage read only by second
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pg_sync <= 2'h0;
		end else begin
			pin_s1 <= {i_out_low, i_fault, i_shutdown};
			pin_s2 <= pin_s1;
			pg_sync <= {pg_sync[0], i_pg_raw};
		end
	end
	assign out_low_s = pin_s2[2];
	assign fault_s = pin_s2[1];
	assign shut_s = pin_s2[0];

	// One microsecond tick for reference ramps
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_cnt <= 7'h0;
		end else if (tick) begin
			tick_cnt <= 7'h0;
		end else begin
			tick_cnt <= tick_cnt + 7'h1;
		end
	end
	assign tick = (tick_cnt == TICK_CYC - 7'h1);

	// selected target; codes in low bits
	always_comb begin
		if (voltage_change_control[REFSEL_BIT]) begin
			target = 20'(reg3_target_two[4:0] * LSB_UV);
		end else begin
			target = 20'(reg3_target_one[4:0] * LSB_UV);
		end
	end

	always_comb begin
		case (ramp_rate_control[RAMP_LSB+:2])
			2'h0: step = STEP_0P88;
			2'h1: step = STEP_1P75;
			2'h2: step = STEP_3P5;
			default: step = STEP_7;
		endcase
		if (state == ST_SOFT) begin
			step = STEP_SOFT;
		end
	end

	assign wait_sel = ~(startup_option[START_BIT] ^ IMMEDIATE_ON_ZERO);
	assign stop = !output_enable[EN_BIT] || fault_s
		|| (shut_s && !reg3_target_two[ALIVE_BIT]);

	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (!stop) begin
					next_state = wait_sel ? ST_WAIT : ST_SOFT;
				end
			end
			ST_WAIT: begin
				if (stop) begin
					next_state = ST_OFF;
				end else if (out_low_s) begin
					next_state = ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (stop) begin
					next_state = ST_OFF;
				end else if (ref_uv == target) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop) begin
					next_state = ST_OFF;
				end else if (slew_req) begin
					next_state = ST_SLEW;
				end
			end
			ST_SLEW: begin
				if (stop) begin
					next_state = ST_OFF;
				end else if (ref_uv == target) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Ramp toward target, clamped so it never overshoots
	always_comb begin
		next_ref = ref_uv;
		if (state == ST_OFF || state == ST_WAIT) begin
			next_ref = 20'h0;
		end else if ((state == ST_SOFT || state == ST_SLEW) && tick) begin
			if (ref_uv < target) begin
				next_ref = (target - ref_uv <= step) ? target : ref_uv + step;
			end else if (ref_uv > target) begin
				next_ref = (ref_uv - target <= step) ? target : ref_uv - step;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ref_uv <= 20'h0;
		end else begin
			ref_uv <= next_ref;
		end
	end
	assign o_ref_uv = ref_uv;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mode <= MODE_PSKIP;
			o_run <= 1'b0;
			o_power_good <= 1'b0;
		end else begin
			o_run <= (next_state != ST_OFF) && (next_state != ST_WAIT);
			if (next_state == ST_SOFT) begin
				o_mode <= MODE_PSKIP;
			end else if (mode_select[MODE_LSB+:2] == MODE_BURST) begin
				o_mode <= MODE_BURST;
			end else if (mode_select[MODE_LSB+:2] == MODE_FCCM) begin
				o_mode <= MODE_FCCM;
			end else begin
				o_mode <= MODE_PSKIP;
			end
			o_power_good <= pg_sync[1] && (next_state == ST_RUN
				|| (next_state == ST_SLEW && reg3_target_one[PGMASK_BIT]));
		end
	end

	// period and high time per rate
	assign o_half_rate = reg3_target_two[FREQ_BIT];
	assign per = o_half_rate ? HALF_PER : FULL_PER;
	assign hi = o_half_rate ? HALF_HI : FULL_HI;
	// phase two shifts by one high time
	assign off = reg3_target_two[PHASE_BIT] ? hi : 8'h0;
	assign shifted = (sw_cnt >= off) ? sw_cnt - off : sw_cnt + per - off;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sw_cnt <= 8'h0;
		end else if (sw_cnt >= per - 8'h1) begin
			sw_cnt <= 8'h0;
		end else begin
			sw_cnt <= sw_cnt + 8'h1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sw_clk <= 1'b0;
			o_cycle_start <= 1'b0;
		end else begin
			o_sw_clk <= (shifted < hi);
			o_cycle_start <= (shifted == 8'h0);
		end
	end

	assign o_edge_rate = reg1_target_one[EDGE_LSB+:2];

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_soft_mode_pskip: assert property (
		state == ST_SOFT |=> o_mode == MODE_PSKIP || $past(next_state) != ST_SOFT)
		else $error("mode not pulse-skipping in soft-start");

	a_mode_follows: assert property (
		state == ST_RUN && next_state == ST_RUN && mode_select[5:4] == MODE_FCCM
		|=> o_mode == MODE_FCCM)
		else $error("mode field not applied");

	a_wait_low_held: assert property (
		state == ST_WAIT && !out_low_s && !stop |=> state == ST_WAIT)
		else $error("left wait before output low");

	a_target_select: assert property (
		voltage_change_control[REFSEL_BIT] |-> target == 20'(reg3_target_two[4:0] * LSB_UV))
		else $error("wrong target selected");

	a_slew_start: assert property (
		state == ST_RUN && slew_req && !stop |=> state == ST_SLEW)
		else $error("slew did not start");

	a_ramp_step: assert property (
		state == ST_SLEW && tick && ref_uv + step < target && !stop
		|=> ref_uv == $past(ref_uv) + $past(step))
		else $error("slew step wrong");

	a_pg_forced: assert property (
		next_state == ST_SLEW && !reg3_target_one[PGMASK_BIT] |=> !o_power_good)
		else $error("power-good not forced low");

	a_full_duty: assert property (
		$fell(o_sw_clk) && !o_half_rate && $past(reg3_target_two, 10) == reg3_target_two
		|-> $past(o_sw_clk, 8) && !$past(o_sw_clk, 9))
		else $error("full-rate high time wrong");

	a_soft_zero: assert property (
		state == ST_SOFT && $past(state) != ST_SOFT |-> ref_uv == 20'h0)
		else $error("soft-start not from zero");

	a_slew_clears: assert property (
		state == ST_RUN && slew_req && !(wr_hit && i_wr.addr == ADDR_VCHANGE)
		|=> !slew_req)
		else $error("slew request not cleared");

	c_soft_done: cover property (state == ST_SOFT ##1 state == ST_RUN);
	c_slew_done: cover property (state == ST_SLEW ##1 state == ST_RUN);
	c_wait_path: cover property (state == ST_WAIT ##1 state == ST_SOFT);
	c_phase_two: cover property (reg3_target_two[PHASE_BIT] && o_cycle_start);
endmodule

// ### verification/host_model.sv
module host_model (
	input wire logic i_ref_clk,
	output buck_pkg::wr_t o_wr,
	output logic [3:0] o_rd_addr,
	input wire logic [7:0] i_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import buck_pkg::*;

	initial begin
		o_wr = '0;
		o_rd_addr = 4'h0;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_wr = '{en: 1'b1, addr: a, data: d};
		@(negedge i_ref_clk);
		// Released bus shows garbage, not the last value
		o_wr = '{en: 1'b0, addr: ~a, data: ~d};
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		o_rd_addr = a;
		@(negedge i_ref_clk);
		d = i_rd_data;
	endtask
endmodule

// ### verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import buck_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end

	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_out_low = 1'b0;
	logic i_fault = 1'b0;
	logic i_shutdown = 1'b0;
	logic i_pg_raw = 1'b0;
	wr_t wr;
	logic [3:0] rd_addr;
	logic [7:0] rd_data, d;
	logic [1:0] mode, edge_rate;
	logic run, pg, sw_clk, cyc, half;
	logic [19:0] ref_uv;
	int err_count = 0;
	int tests_run = 0;
	int cnt = 0;
	int p, h, d0, d1;
	logic [7:0] rst_tab [10] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_RAMP,
		RST_TARGET, RST_TARGET, RST_TARGET, 8'h00, 8'h00};

	always #5 i_ref_clk = ~i_ref_clk;
	// Free time base to see phase offsets
	always @(posedge i_ref_clk) cnt <= cnt + 1;

	buck_regulator_control i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wr(wr),
		.i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_out_low(i_out_low),
		.i_fault(i_fault), .i_shutdown(i_shutdown), .i_pg_raw(i_pg_raw), .o_mode(mode),
		.o_run(run), .o_power_good(pg), .o_ref_uv(ref_uv), .o_sw_clk(sw_clk),
		.o_cycle_start(cyc), .o_half_rate(half), .o_edge_rate(edge_rate));
	host_model i_host (.i_ref_clk(i_ref_clk), .o_wr(wr), .o_rd_addr(rd_addr),
		.i_rd_data(rd_data));

	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Poll status until masked bits match, bounded
	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do begin
			i_host.rd(ADDR_STATUS, d);
			n++;
		end while ((d & m) !== v && n < 3000);
		`CHK(d & m, v)
	endtask

	task automatic meas(output int per, output int hi, output int dl);
		int c;
		@(posedge sw_clk);
		c = 0;
		hi = 0;
		per = 0;
		while (per == 0 && c < 300) begin
			@(negedge i_ref_clk);
			c++;
			if (sw_clk === 1'b0 && hi == 0) hi = c - 1;
			if (sw_clk === 1'b1 && hi != 0) per = c - 1;
		end
		c = 0;
		while (cyc !== 1'b1 && c < 300) begin
			@(negedge i_ref_clk);
			c++;
		end
		dl = (per > 0) ? cnt % per : 0;
	endtask

	initial begin
		#1000000;
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (16) @(negedge i_ref_clk);
		i_nrst = 1'b1;
		for (int i = 0; i < 10; i++) begin
			i_host.rd(i[3:0], d);
			`CHK(d, rst_tab[i])
		end
		`CHK({run, mode, edge_rate, half}, 6'h00)
		$display("test reset values done");
		i_pg_raw = 1'b1;
		i_host.wr(ADDR_T1, 8'h01);
		i_host.wr(ADDR_MODE, 8'h20);
		i_host.wr(ADDR_ENABLE, 8'h04);
		wait_st(8'h07, 8'h01);
		repeat (50) @(negedge i_ref_clk);
		`CHK(run, 1'b0)
		i_out_low = 1'b1;
		wait_st(8'h02, 8'h02);
		`CHK({run, mode}, 3'b100)
		`CHK(ref_uv < 20'd2401, 1'b1)
		wait_st(8'h24, 8'h24);
		`CHK(ref_uv, 20'd12500)
		for (int m = 0; m < 4; m++) begin
			i_host.wr(ADDR_MODE, 8'(m << MODE_LSB));
			repeat (3) @(negedge i_ref_clk);
			`CHK(mode, (m == 3) ? MODE_PSKIP : 2'(m))
		end
		$display("test enable and modes done");
		i_host.wr(ADDR_T2, 8'h03);
		i_host.wr(ADDR_VCHANGE, 8'h30);
		wait_st(8'h08, 8'h08);
		`CHK(pg, 1'b0)
		i_host.rd(ADDR_VCHANGE, d);
		`CHK(d, 8'h20)
		wait_st(8'h0c, 8'h04);
		`CHK(ref_uv, 20'd37500)
		i_host.wr(ADDR_RAMP, 8'h00);
		i_host.wr(ADDR_T1, 8'h21);
		i_host.wr(ADDR_VCHANGE, 8'h10);
		repeat (1500) @(negedge i_ref_clk);
		`CHK(ref_uv > 20'd20000 && ref_uv < 20'd30000, 1'b1)
		`CHK(pg, 1'b1)
		wait_st(8'h0c, 8'h04);
		`CHK(ref_uv, 20'd12500)
		$display("test slews done");
		meas(p, h, d0);
		`CHK({p[7:0], h[7:0]}, {FULL_PER, FULL_HI})
		i_host.wr(ADDR_T2, 8'h43);
		repeat (100) @(negedge i_ref_clk);
		meas(p, h, d1);
		`CHK((d1 - d0 + p) % p, int'(FULL_HI))
		i_host.wr(ADDR_T2, 8'h23);
		repeat (200) @(negedge i_ref_clk);
		meas(p, h, d0);
		`CHK({p[7:0], h[7:0], half}, {HALF_PER, HALF_HI, 1'b1})
		i_host.wr(ADDR_T2, 8'h63);
		repeat (200) @(negedge i_ref_clk);
		meas(p, h, d1);
		`CHK((d1 - d0 + p) % p, int'(HALF_HI))
		i_host.wr(ADDR_R1_T1, 8'hd9);
		repeat (2) @(negedge i_ref_clk);
		`CHK(edge_rate, 2'h3)
		$display("test clocks done");
		i_host.wr(ADDR_T2, 8'he3);
		i_shutdown = 1'b1;
		repeat (20) @(negedge i_ref_clk);
		`CHK(run, 1'b1)
		i_host.wr(ADDR_T2, 8'h63);
		repeat (10) @(negedge i_ref_clk);
		`CHK(run, 1'b0)
		i_shutdown = 1'b0;
		i_fault = 1'b1;
		repeat (10) @(negedge i_ref_clk);
		`CHK({run, ref_uv}, 21'h0)
		i_out_low = 1'b0;
		i_host.wr(ADDR_STARTUP, 8'h04);
		i_fault = 1'b0;
		wait_st(8'h02, 8'h02);
		`CHK(ref_uv < 20'd2401, 1'b1)
		$display("test shutdown and fault done");
		wrap_up();
	end
endmodule
